/* File: verilog/tgc_trace_gate.sv */
`timescale 1ns/1ns
// Function
// - all visible registers sit inside one 4KB region
// - indices 0x3C0-0x3FF, top 256 bytes, hold management registers
// - indices 0x380-0x3BF hold topology and integration registers
// - trace gate high while tracing allowed, low while suppressed
// - start and stop each fed by selected address matches and watchpoints
// - any selected start input turns latch on, output high
// - any selected stop input turns latch off, output low
// - enable bit decides whether latch gates trace; clear means no effect
// - latch output always offered as an event resource
// - polarity bit picks include or exclude range use
// - trace needs enabling event and latch on or latch bypassed
// - include needs a range hit, exclude needs a range miss
// - stop keeps latch on through block, off at next waypoint
// - gate changes between waypoints act at next waypoint
// - exclude suppresses a block only if range covers whole block
module tgc_trace_gate (
  input wire logic sys_clk, // core clock
  input wire logic rstn, // async reset
  input wire logic instr_valid, // non-waypoint instruction retires
  input wire logic waypoint, // waypoint instruction retires
  input wire logic [tgc_pkg::NUM_SAC-1:0] single_address_match, // per instruction
  input wire logic [tgc_pkg::NUM_ARC-1:0] address_range_match, // per instruction
  input wire logic [tgc_pkg::NUM_WPT-1:0] watchpoint_in, // core watchpoints
  input wire logic [tgc_pkg::NUM_RES-1:0] res_in, // event resources
  input wire tgc_pkg::tgc_ctrl_t ctrl, // enable and polarity
  input wire tgc_pkg::tgc_sac_sel_t start_stop_select_reg, // sac selection
  input wire tgc_pkg::tgc_wpt_sel_t watchpoint_start_stop_select_reg, // wpt sel
  input wire tgc_pkg::tgc_event_t gate_event_reg, // enabling event
  input wire logic [tgc_pkg::ADDR_W-1:0] probe_addr, // byte address to classify
  output logic trace_gate, // tracing permitted
  output logic ss_resource, // latch as resource
  output tgc_pkg::tgc_region_t probe_class // class of probe_addr
);

  // ******************************************************
  // region decode
  // ******************************************************

  logic [tgc_pkg::IDX_W-1:0] probe_idx;
  logic is_mgmt;
  logic is_topo;
  tgc_pkg::tgc_region_t nxt_class;
  tgc_pkg::tgc_region_t class_ff;

  // word index inside the 4KB region
  assign probe_idx = probe_addr[tgc_pkg::ADDR_W-1:tgc_pkg::IDX_LSB];
  assign is_mgmt = (probe_idx >= tgc_pkg::MGMT_LO) && (probe_idx <= tgc_pkg::MGMT_HI);
  assign is_topo = (probe_idx >= tgc_pkg::TOPO_LO) && (probe_idx <= tgc_pkg::TOPO_HI);
  assign nxt_class = is_mgmt ? tgc_pkg::TGC_REG_MGMT :
                     is_topo ? tgc_pkg::TGC_REG_TOPO : tgc_pkg::TGC_REG_GENERAL;

  // registered class output
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      class_ff <= tgc_pkg::TGC_REG_GENERAL;
    else
      class_ff <= nxt_class;
  end

  assign probe_class = class_ff;

  // ******************************************************
  // start/stop inputs
  // ******************************************************

  logic instr_any;
  logic start_now;
  logic stop_now;

  // waypoint is itself the last instruction of its block
  assign instr_any = instr_valid | waypoint;
  // start from selected sacs and watchpoints
  assign start_now = (instr_any && |(single_address_match & start_stop_select_reg.start))
                   || |(watchpoint_in & watchpoint_start_stop_select_reg.start);
  // stop from selected sacs and watchpoints
  assign stop_now = (instr_any && |(single_address_match & start_stop_select_reg.stop))
                  || |(watchpoint_in & watchpoint_start_stop_select_reg.stop);

  // ******************************************************
  // start/stop latch
  // ******************************************************

  logic latch_ff;
  logic nxt_latch;
  logic stop_acc_ff;
  logic nxt_stop_acc;
  logic stop_blk;
  logic on_blk;

  // multiple stops in a block act as one
  assign stop_blk = stop_acc_ff | stop_now;
  // block counts as on if latch on or started inside it
  assign on_blk = latch_ff | start_now;
  assign nxt_stop_acc = waypoint ? 1'b0 : stop_blk;
  // stop lands at the waypoint and beats a start in the same block
  // start turns latch on at once
  assign nxt_latch = (waypoint && stop_blk) ? 1'b0 :
                     start_now ? 1'b1 : latch_ff;

  // latch and pending stop
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      latch_ff <= 1'b0;
      stop_acc_ff <= 1'b0;
    end
    else
    begin
      latch_ff <= nxt_latch;
      stop_acc_ff <= nxt_stop_acc;
    end
  end

  assign ss_resource = latch_ff;

  // ******************************************************
  // enabling event
  // ******************************************************

  logic sel_is_latch;
  logic evt_raw;
  logic evt_now;
  logic evt_acc_ff;
  logic evt_blk;

  // latch takes the reserved resource slot
  assign sel_is_latch = gate_event_reg.sel == tgc_pkg::RES_SS_IDX;
  assign evt_raw = sel_is_latch ? latch_ff : res_in[gate_event_reg.sel];
  assign evt_now = evt_raw ^ gate_event_reg.invert;
  // an event seen mid-block is held until the waypoint
  assign evt_blk = evt_acc_ff | evt_now;

  // event accumulation over the block
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      evt_acc_ff <= 1'b0;
    else
      evt_acc_ff <= waypoint ? 1'b0 : evt_blk;
  end

  // ******************************************************
  // include/exclude ranges
  // ******************************************************

  logic arc_hit;
  logic incl_acc_ff;
  logic excl_all_ff;
  logic incl_blk;
  logic excl_all_blk;
  logic range_ok;

  assign arc_hit = |(address_range_match & ctrl.arc_sel);
  // include: any instruction of the block in range
  assign incl_blk = incl_acc_ff | (instr_any & arc_hit);
  // exclude only if every instruction of the block is in range
  assign excl_all_blk = excl_all_ff & (!instr_any | arc_hit);
  // include needs a hit, exclude needs a miss
  assign range_ok = ctrl.excl_mode ? !excl_all_blk : incl_blk;

  // range accumulation over the block
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      incl_acc_ff <= 1'b0;
      excl_all_ff <= 1'b1;
    end
    else
    begin
      incl_acc_ff <= waypoint ? 1'b0 : incl_blk;
      excl_all_ff <= waypoint ? 1'b1 : excl_all_blk;
    end
  end

  // ******************************************************
  // final gate
  // ******************************************************

  logic gate_ff;
  logic nxt_gate;
  logic ss_ok;

  // enable bit decides whether the latch gates
  assign ss_ok = !ctrl.ss_enable | on_blk;
  // event and latch condition combined with range test
  assign nxt_gate = evt_blk & ss_ok & range_ok;

  // gate moves only at a waypoint
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      gate_ff <= 1'b0;
    else if (waypoint)
      gate_ff <= nxt_gate;
  end

  assign trace_gate = gate_ff;

  // ******************************************************
  // checks
  // ******************************************************

  a_gate_after_reset: assert property (
    @(posedge sys_clk) $rose(rstn) |-> !trace_gate && !ss_resource)
    else $error("gate or latch high right after reset");

  a_latch_start_on: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    start_now && !(waypoint && stop_blk) |=> ss_resource)
    else $error("start did not turn latch on");

  a_latch_stop_off: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    waypoint && stop_now |=> !ss_resource)
    else $error("stop at waypoint left latch on");

  a_stop_holds_block: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ss_resource && !waypoint |=> ss_resource)
    else $error("latch dropped between waypoints");

  a_stop_then_start: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    stop_now && !waypoint ##1 (start_now && waypoint) |=> !ss_resource)
    else $error("stop before start in block left latch on");

  a_gate_waypoint_only: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !waypoint |=> $stable(trace_gate))
    else $error("gate moved between waypoints");

  a_event_mid_block: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (evt_now && !waypoint && !ctrl.ss_enable && !ctrl.excl_mode)
      ##1 (waypoint && arc_hit && $stable(ctrl)) |=> trace_gate)
    else $error("mid block event lost at waypoint");

  a_gate_needs_event: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    waypoint && !evt_blk |=> !trace_gate)
    else $error("gate opened without event");

  a_latch_gates: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    waypoint && ctrl.ss_enable && !ss_resource && !start_now |=> !trace_gate)
    else $error("gate opened with latch off and enabled");

  a_latch_bypass: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    waypoint && !ctrl.ss_enable && evt_blk && range_ok |=> trace_gate)
    else $error("bypassed latch still blocked gate");

  a_latch_resource: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    waypoint && ss_resource && !stop_blk && gate_event_reg == '0
      && !ctrl.ss_enable && range_ok |=> trace_gate && ss_resource)
    else $error("latch resource did not enable gate");

  a_include_miss: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    waypoint && !ctrl.excl_mode && !incl_blk |=> !trace_gate)
    else $error("include mode traced without range hit");

  a_exclude_whole: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    waypoint && ctrl.excl_mode && excl_all_blk |=> !trace_gate)
    else $error("fully excluded block traced");

  a_exclude_partial: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (instr_valid && !waypoint && !arc_hit) ##1 (waypoint && ctrl.excl_mode)
      |-> !excl_all_blk)
    else $error("partly excluded block counted as excluded");

  a_region_mgmt: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    int'(probe_addr) >= tgc_pkg::REGION_BYTES - tgc_pkg::MGMT_BYTES
      |=> probe_class == tgc_pkg::TGC_REG_MGMT)
    else $error("top 256 bytes not classed as management");

  a_region_topo: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    probe_addr >= 12'hE00 && probe_addr < 12'hF00
      |=> probe_class == tgc_pkg::TGC_REG_TOPO)
    else $error("topology window misclassed");

endmodule : tgc_trace_gate

/* File: verilog/tgc_pkg.sv */
package tgc_pkg;

  // ******************************************************
  // sizes of the match and resource inputs
  // ******************************************************
  localparam int NUM_SAC = 16;
  localparam int NUM_ARC = 8;
  localparam int NUM_WPT = 8;
  localparam int NUM_RES = 16;
  localparam int RES_W = 4;
  // resource slot carrying the start/stop latch output
  localparam logic [RES_W-1:0] RES_SS_IDX = 4'h0;

  // ******************************************************
  // register region layout
  // ******************************************************
  localparam int REGION_BYTES = 4096;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;
  localparam int MGMT_BYTES = 256;
  localparam logic [IDX_W-1:0] MGMT_LO = 10'h3C0;
  localparam logic [IDX_W-1:0] MGMT_HI = 10'h3FF;
  localparam logic [IDX_W-1:0] TOPO_LO = 10'h380;
  localparam logic [IDX_W-1:0] TOPO_HI = 10'h3BF;

  // class of a register index inside the region
  typedef enum logic [1:0] {TGC_REG_GENERAL, TGC_REG_TOPO, TGC_REG_MGMT} tgc_region_t;

  // ******************************************************
  // control carriers
  // ******************************************************
  typedef struct packed {
    logic ss_enable;
    logic excl_mode;
    logic [NUM_ARC-1:0] arc_sel;
  } tgc_ctrl_t;

  typedef struct packed {
    logic [NUM_SAC-1:0] start;
    logic [NUM_SAC-1:0] stop;
  } tgc_sac_sel_t;

  typedef struct packed {
    logic [NUM_WPT-1:0] start;
    logic [NUM_WPT-1:0] stop;
  } tgc_wpt_sel_t;

  typedef struct packed {
    logic invert;
    logic [RES_W-1:0] sel;
  } tgc_event_t;

endpackage : tgc_pkg

/* File: bench/tgc_core_model.sv */
`timescale 1ns/1ns
// ********************
// core side: retiring instruction stream and watchpoints
// ********************
module tgc_core_model (
  input wire logic sys_clk, // core clock
  input wire logic rstn, // async reset
  input wire logic go, // stream running
  input wire logic slow, // insert idle cycles
  input wire logic [31:0] rnd, // random word per cycle
  output logic instr_valid, // plain instruction
  output logic waypoint, // waypoint instruction
  output logic [tgc_pkg::NUM_SAC-1:0] single_address_match, // address hits
  output logic [tgc_pkg::NUM_ARC-1:0] address_range_match, // range hits
  output logic [tgc_pkg::NUM_WPT-1:0] watchpoint_in // watchpoint hits
);
  logic act;

  // slow pace idles on about half the cycles
  assign act = go && !(slow && rnd[31]);

  // match lines carry junk outside instructions, as a real core may
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      instr_valid <= 1'b0;
      waypoint <= 1'b0;
      single_address_match <= 16'h0000;
      address_range_match <= 8'h00;
      watchpoint_in <= 8'h00;
    end
    else
    begin
      instr_valid <= act && rnd[0];
      waypoint <= act && (rnd[3:1] == 3'h0);
      single_address_match <= rnd[8] ? (16'h0001 << rnd[7:4]) : 16'h0000;
      address_range_match <= rnd[16] ? 8'hFF : rnd[24:17];
      watchpoint_in <= (go && rnd[27:25] == 3'h0) ? (8'h01 << rnd[30:28]) : 8'h00;
    end
  end
endmodule : tgc_core_model

/* File: bench/tb_trace_gate_control.sv */
`timescale 1ns/1ns
module tb_trace_gate_control;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [31:0] rnd = 32'h0;
  logic instr_valid;
  logic waypoint;
  logic [15:0] single_address_match;
  logic [7:0] address_range_match;
  logic [7:0] watchpoint_in;
  logic [15:0] res_in = 16'h0;
  tgc_pkg::tgc_ctrl_t ctrl = 10'h0;
  tgc_pkg::tgc_sac_sel_t start_stop_select_reg = 32'h0;
  tgc_pkg::tgc_wpt_sel_t watchpoint_start_stop_select_reg = 16'h0;
  tgc_pkg::tgc_event_t gate_event_reg = 5'h0;
  logic [11:0] probe_addr = 12'h0;
  logic trace_gate;
  logic ss_resource;
  tgc_pkg::tgc_region_t probe_class;
  tgc_pkg::tgc_region_t m_cls = tgc_pkg::TGC_REG_GENERAL;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  int m_gate = 0;
  int m_latch = 0;
  int e_acc = 0;
  int p_acc = 0;
  int i_acc = 0;
  int x_all = 1;

  always #2 sys_clk = ~sys_clk;

  tgc_core_model i_core (.sys_clk, .rstn, .go, .slow, .rnd, .instr_valid, .waypoint,
    .single_address_match, .address_range_match, .watchpoint_in);

  tgc_trace_gate i_dut (.sys_clk, .rstn, .instr_valid, .waypoint, .single_address_match,
    .address_range_match, .watchpoint_in, .res_in, .ctrl, .start_stop_select_reg,
    .watchpoint_start_stop_select_reg, .gate_event_reg, .probe_addr, .trace_gate,
    .ss_resource, .probe_class);

  // ********************
  // reference model: block accumulators closed at each waypoint
  // ********************
  always @(posedge sys_clk or negedge rstn)
  begin : ref_model
    int ins, st, sp, ev, ih;
    if (!rstn)
    begin
      m_gate = 0; m_latch = 0; e_acc = 0; p_acc = 0; i_acc = 0; x_all = 1;
      m_cls = tgc_pkg::TGC_REG_GENERAL;
    end
    else
    begin
      ins = instr_valid | waypoint;
      st = (ins && (single_address_match & start_stop_select_reg.start) != 0)
        || (watchpoint_in & watchpoint_start_stop_select_reg.start) != 0;
      sp = (ins && (single_address_match & start_stop_select_reg.stop) != 0)
        || (watchpoint_in & watchpoint_start_stop_select_reg.stop) != 0;
      ev = (gate_event_reg.sel == tgc_pkg::RES_SS_IDX) ? m_latch
        : int'(res_in[gate_event_reg.sel]);
      ev = ev ^ int'(gate_event_reg.invert);
      ih = ins && (address_range_match & ctrl.arc_sel) != 0;
      e_acc |= ev;
      p_acc |= sp;
      i_acc |= ih;
      if (ins && !ih)
        x_all = 0;
      m_cls = (probe_addr[11:2] >= 10'h3C0) ? tgc_pkg::TGC_REG_MGMT :
        (probe_addr[11:2] >= 10'h380) ? tgc_pkg::TGC_REG_TOPO : tgc_pkg::TGC_REG_GENERAL;
      if (waypoint)
      begin
        m_gate = e_acc && (!ctrl.ss_enable || m_latch || st)
          && (ctrl.excl_mode ? !x_all : i_acc);
        m_latch = p_acc ? 0 : (m_latch | st);
        e_acc = 0; p_acc = 0; i_acc = 0; x_all = 1;
      end
      else
        m_latch = m_latch | st;
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_cls(input tgc_pkg::tgc_region_t got, input tgc_pkg::tgc_region_t exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: class got %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cls

  // compare every settled cycle, reset included
  always @(negedge sys_clk)
  begin
    chk_bit(trace_gate, m_gate[0], "gate");
    chk_bit(ss_resource, m_latch[0], "latch");
    chk_cls(probe_class, m_cls);
  end

  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // one configuration per test, applied under reset
  task automatic run_test(input int i);
    @(posedge sys_clk);
    rstn <= 1'b0;
    go <= 1'b0;
    slow <= i[2];
    // software picks event, matches and watchpoints
    ctrl <= {i[0], i[1], 8'($urandom)};
    start_stop_select_reg <= $urandom;
    watchpoint_start_stop_select_reg <= 16'($urandom);
    // invert fixed per test so that test 0 selects the plain latch slot
    gate_event_reg <= {i[1] ^ i[2], 4'(i * 2)};
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b1;
    repeat (1500) @(posedge sys_clk);
    go <= 1'b0;
    $display("test %0d done", i);
  endtask : run_test

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    void'($urandom(32'h582A49EB));
    // random stimulus on every rising edge, child of the seeded thread
    fork
      forever
      begin
        @(posedge sys_clk);
        rnd <= $urandom;
        res_in <= 16'($urandom);
        probe_addr <= 12'($urandom);
      end
    join_none
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++)
      run_test(i);
    conclude();
  end
endmodule : tb_trace_gate_control
